// file: logic/beam_fire_pkg.sv
// Shared constants for the transmit beam firing control block.
// Assumes a single 200 MHz clock. Each rising clock edge is taken as one fine delay step.
`default_nettype none

package beam_fire_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int CHANNELS       = 8;
    localparam int PATTERN_MAX    = 64;
    localparam int ADDR_W         = 5;
    localparam int DELAY_W        = 22;
    localparam int TOP_W          = 14;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_DELAY_BASE  = 5'h00;  // Channel delay, 00h..07h
    localparam logic [4:0] ADDR_PPAT_BASE   = 5'h08;  // Positive pattern, 08h..0Fh
    localparam logic [4:0] ADDR_NPAT_BASE   = 5'h10;  // Negative pattern, 10h..17h
    localparam logic [4:0] ADDR_PPAT_ALL    = 5'h18;  // Positive pattern, all channels
    localparam logic [4:0] ADDR_NPAT_ALL    = 5'h19;  // Negative pattern, all channels
    localparam logic [4:0] ADDR_TOP_CONTROL = 5'h1A;  // firing_top_control

    // ------------------------------------------------------------
    // firing_top_control fields
    // ------------------------------------------------------------
    localparam int TOP_CW_BIT      = 12;
    localparam int TOP_ALT_BIT     = 11;
    localparam int TOP_PLL_BIT     = 10;
    localparam int TOP_DIV_MSB     = 9;
    localparam int TOP_DIV_LSB     = 3;
    localparam int TOP_LEN_MSB     = 2;
    localparam int TOP_LEN_LSB     = 0;
    localparam logic [13:0] TOP_RESET      = 14'h0000;
    localparam logic [13:0] TOP_WRITE_MASK = 14'h1FFF;  // Top bit is reserved, reads zero

    // ------------------------------------------------------------
    // Channel delay fields
    // ------------------------------------------------------------
    localparam int DLY_PWA_BIT     = 21;
    localparam int DLY_PWA_MSB     = 19;
    localparam int DLY_PWA_LSB     = 17;
    localparam int DLY_COARSE_MSB  = 16;
    localparam int DLY_COARSE_LSB  = 3;
    localparam int DLY_FINE_MSB    = 2;
    localparam int DLY_FINE_LSB    = 0;
    localparam logic [21:0] DELAY_RESET = 22'h000000;

    // ------------------------------------------------------------
    // Patterns and timing
    // ------------------------------------------------------------
    localparam logic [63:0] P_PATTERN_RESET = 64'h5555555555555555;
    localparam logic [63:0] N_PATTERN_RESET = 64'hAAAAAAAAAAAAAAAA;
    localparam logic [63:0] CW_P_PATTERN    = 64'h5555555555555555;  // 1 then 0, from bit 0
    localparam logic [63:0] CW_N_PATTERN    = 64'hAAAAAAAAAAAAAAAA;  // 0 then 1, from bit 0
    localparam int          FINE_PER_COARSE = 8;      // 6.25 ns over 0.78 ns
    localparam int          FINE_SHIFT      = 3;      // log2 of FINE_PER_COARSE
    localparam real         COARSE_STEP_NS  = 6.25;
    localparam real         FINE_STEP_NS    = 0.78;
    localparam real         LATENCY_NS      = 37.5;   // 6 internal fast clock cycles
    localparam int          LATENCY_FINE    = $rtoi(LATENCY_NS / COARSE_STEP_NS) * FINE_PER_COARSE;
    localparam logic [7:0]  DIV_ZERO_VALUE  = 8'h80;  // Divider field of zero means 128

    // Firing sequencer states, Gray along idle, latency, firing, done
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_LATENCY = 2'b01,
        ST_FIRING  = 2'b11,
        ST_DONE    = 2'b10
    } fire_state_t;

endpackage : beam_fire_pkg

`default_nettype wire

// file: logic/beam_fire_control.sv
// Eight-channel transmit beam firing control: delay counting and pattern shifting.
// Assumes register writes arrive already decoded from the serial port, one per cycle,
// and that one i_clock period is one fine delay step.
//
// Summary of operation
// - After trigger rises, wait the fixed latency before any channel counts delay.
// - A channel starts its pattern when its counter reaches coarse plus fine delay.
// - Continuous wave uses preset patterns: positive 1,0 and negative 0,1.
// - In continuous wave, writes to shared pattern registers 18h and 19h are ignored.
// - Continuous wave replays the pattern circularly while the trigger stays high.
// - Alternate polarity: first trigger sends pattern as stored, the next one inverted.
// - Alternation happens only when enabled; otherwise every firing is non-inverted.
// - Channel delays persist across firings and mode changes until reset.
// - Top control: reserved, cw select, alternate enable, pll enable, divider, length.
// - Each pattern bit lasts divider times the fast clock period.
// - Length code picks bits fired: 0 gives 4 bits, 1 gives 8 bits.
// - Width adjust: positive starts k fine steps later and is 2k steps narrower.
// - Width adjust off: positive and negative start together with equal widths.
// - Programmed delays are counted after the fixed latency, which is not included.
// - Pattern bits go out from least to most significant until length runs out.
// - Coarse step is 6.25 ns, fine step 0.78 ns; delay is their sum.
`timescale 1ns/1ps
`default_nettype none

module beam_fire_control #(
    parameter int CHANNELS = beam_fire_pkg::CHANNELS
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_rst,
    input  wire logic                 i_fire_trigger,
    input  wire logic                 i_reg_write,
    input  wire logic [4:0]           i_reg_addr,
    input  wire logic [63:0]          i_reg_data,
    output logic      [13:0]          o_top_control,
    output logic                      o_pll_enable,
    output logic                      o_firing_active,
    output logic      [CHANNELS-1:0]  o_p_drive,
    output logic      [CHANNELS-1:0]  o_n_drive
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [13:0] top_control;
    logic [21:0] ch_delay [CHANNELS];
    logic [63:0] ch_ppat  [CHANNELS];
    logic [63:0] ch_npat  [CHANNELS];

    // Field decode from the top control register
    wire        cw_select   = top_control[beam_fire_pkg::TOP_CW_BIT];
    wire        alt_enable  = top_control[beam_fire_pkg::TOP_ALT_BIT];
    wire [6:0]  rate_div    = top_control[beam_fire_pkg::TOP_DIV_MSB:beam_fire_pkg::TOP_DIV_LSB];
    wire [2:0]  len_code    = top_control[beam_fire_pkg::TOP_LEN_MSB:beam_fire_pkg::TOP_LEN_LSB];
    wire        wr_top      = i_reg_write && (i_reg_addr == beam_fire_pkg::ADDR_TOP_CONTROL);
    wire        wr_pall     = i_reg_write && (i_reg_addr == beam_fire_pkg::ADDR_PPAT_ALL) && !cw_select;
    wire        wr_nall     = i_reg_write && (i_reg_addr == beam_fire_pkg::ADDR_NPAT_ALL) && !cw_select;

    // Bit width in fine ticks: divider counts fast clock periods, a zero field means 128
    wire [7:0]  div_eff     = (rate_div == 7'h00) ? beam_fire_pkg::DIV_ZERO_VALUE : {1'b0, rate_div};
    wire [10:0] bit_width   = {div_eff, 3'b000};

    // Pattern length from the code; the final index is length minus one
    logic [5:0] last_index;
    always_comb
    begin
        case (len_code)
            3'h0:    last_index = 6'h03;
            3'h1:    last_index = 6'h07;
            3'h2:    last_index = 6'h0F;
            3'h3:    last_index = 6'h17;
            3'h4:    last_index = 6'h1F;
            3'h5:    last_index = 6'h27;
            3'h6:    last_index = 6'h2F;
            default: last_index = 6'h3F;
        endcase
    end

    // Top control write; reserved bit is masked so it always reads zero
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            top_control <= beam_fire_pkg::TOP_RESET;
        else if (wr_top)
            top_control <= i_reg_data[13:0] & beam_fire_pkg::TOP_WRITE_MASK;
    end

    // ------------------------------------------------------------
    // Firing sequencer
    // ------------------------------------------------------------
    beam_fire_pkg::fire_state_t state;
    beam_fire_pkg::fire_state_t next_state;
    logic        trigger_prev;
    logic [5:0]  latency_count;
    logic [17:0] fire_time;          // Fine ticks since the latency elapsed
    logic        polarity_phase;     // Next firing is the inverted one
    logic        fire_invert;        // Current firing sends inverted patterns
    logic [CHANNELS-1:0] ch_done;

    wire trigger_rise = i_fire_trigger && !trigger_prev;
    wire latency_end  = (latency_count == 6'(beam_fire_pkg::LATENCY_FINE - 1));

    // Dropping the trigger always aborts back to idle, mid-pattern or not
    always_comb
    begin
        next_state = state;
        case (state)
            beam_fire_pkg::ST_IDLE:
                if (trigger_rise)
                    next_state = beam_fire_pkg::ST_LATENCY;
            beam_fire_pkg::ST_LATENCY:
                if (!i_fire_trigger)
                    next_state = beam_fire_pkg::ST_IDLE;
                else if (latency_end)
                    next_state = beam_fire_pkg::ST_FIRING;
            beam_fire_pkg::ST_FIRING:
                if (!i_fire_trigger)
                    next_state = beam_fire_pkg::ST_IDLE;
                else if (&ch_done && !cw_select)
                    next_state = beam_fire_pkg::ST_DONE;
            beam_fire_pkg::ST_DONE:
                if (!i_fire_trigger)
                    next_state = beam_fire_pkg::ST_IDLE;
            default:
                next_state = beam_fire_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            state        <= beam_fire_pkg::ST_IDLE;
            trigger_prev <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            trigger_prev <= i_fire_trigger;
        end
    end

    // Latency and firing-time counters; the latency is outside the programmed delay
    always_ff @(posedge i_clock)
    begin
        if (i_rst || state != beam_fire_pkg::ST_LATENCY)
            latency_count <= 6'h00;
        else
            latency_count <= latency_count + 6'h01;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst || state != beam_fire_pkg::ST_FIRING)
            fire_time <= 18'h00000;
        else if (fire_time != 18'h3FFFF)
            fire_time <= fire_time + 18'h00001;
    end

    // Polarity alternation is decided at each trigger rise and held for that firing
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            polarity_phase <= 1'b0;
            fire_invert    <= 1'b0;
        end
        else if (state == beam_fire_pkg::ST_IDLE && trigger_rise)
        begin
            fire_invert    <= alt_enable && polarity_phase;
            polarity_phase <= alt_enable && !polarity_phase;
        end
    end

    // ------------------------------------------------------------
    // Per-channel registers and pattern engines
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_channel
            wire wr_delay = i_reg_write && (i_reg_addr == 5'(beam_fire_pkg::ADDR_DELAY_BASE + ch));
            wire wr_ppat  = i_reg_write && (i_reg_addr == 5'(beam_fire_pkg::ADDR_PPAT_BASE + ch));
            wire wr_npat  = i_reg_write && (i_reg_addr == 5'(beam_fire_pkg::ADDR_NPAT_BASE + ch));

            // Delays only change on an explicit write, so they survive any number of firings
            always_ff @(posedge i_clock)
            begin
                if (i_rst)
                    ch_delay[ch] <= beam_fire_pkg::DELAY_RESET;
                else if (wr_delay)
                    ch_delay[ch] <= i_reg_data[21:0];
            end

            // A per-channel write and a shared write never coincide, one address per cycle
            always_ff @(posedge i_clock)
            begin
                if (i_rst)
                begin
                    ch_ppat[ch] <= beam_fire_pkg::P_PATTERN_RESET;
                    ch_npat[ch] <= beam_fire_pkg::N_PATTERN_RESET;
                end
                else
                begin
                    if (wr_ppat || wr_pall)
                        ch_ppat[ch] <= i_reg_data;
                    if (wr_npat || wr_nall)
                        ch_npat[ch] <= i_reg_data;
                end
            end

            // Total delay in fine ticks: eight fine steps to one coarse step
            wire [13:0] coarse_step = ch_delay[ch][beam_fire_pkg::DLY_COARSE_MSB:beam_fire_pkg::DLY_COARSE_LSB];
            wire [2:0]  fine_step   = ch_delay[ch][beam_fire_pkg::DLY_FINE_MSB:beam_fire_pkg::DLY_FINE_LSB];
            wire [17:0] total_delay = {1'b0, coarse_step, 3'b000} + {15'h0000, fine_step};
            wire        pwa_on      = ch_delay[ch][beam_fire_pkg::DLY_PWA_BIT];
            wire [10:0] pwa_steps   = pwa_on ?
                {8'h00, ch_delay[ch][beam_fire_pkg::DLY_PWA_MSB:beam_fire_pkg::DLY_PWA_LSB]} : 11'h000;

            logic        running;
            logic [5:0]  bit_index;
            logic [10:0] bit_offset;

            wire start_now = (state == beam_fire_pkg::ST_FIRING) && !running && !ch_done[ch]
                             && (fire_time == total_delay);
            wire bit_end   = (bit_offset == bit_width - 11'h001);
            wire last_bit  = (bit_index == last_index);

            always_ff @(posedge i_clock)
            begin
                if (i_rst || state != beam_fire_pkg::ST_FIRING)
                begin
                    running    <= 1'b0;
                    ch_done[ch] <= 1'b0;
                    bit_index  <= 6'h00;
                    bit_offset <= 11'h000;
                end
                else if (start_now)
                    running <= 1'b1;
                else if (running)
                begin
                    bit_offset <= bit_end ? 11'h000 : bit_offset + 11'h001;
                    if (bit_end && last_bit && cw_select)
                        bit_index <= 6'h00;
                    else if (bit_end && last_bit)
                    begin
                        running     <= 1'b0;
                        ch_done[ch] <= 1'b1;
                    end
                    else if (bit_end)
                        bit_index <= bit_index + 6'h01;
                end
            end

            // Pattern source: fixed presets in continuous wave, stored patterns otherwise
            wire [63:0] p_src   = cw_select ? beam_fire_pkg::CW_P_PATTERN : ch_ppat[ch];
            wire [63:0] n_src   = cw_select ? beam_fire_pkg::CW_N_PATTERN : ch_npat[ch];
            wire        p_bit   = p_src[bit_index] ^ fire_invert;
            wire        n_bit   = n_src[bit_index] ^ fire_invert;
            // Positive window trimmed k ticks at each end; back-to-back ones gain a 2k gap
            wire        p_window = (bit_offset >= pwa_steps) && (bit_offset < bit_width - pwa_steps);

            // Outputs registered, so both drives share the same one-cycle lag
            always_ff @(posedge i_clock)
            begin
                if (i_rst)
                begin
                    o_p_drive[ch] <= 1'b0;
                    o_n_drive[ch] <= 1'b0;
                end
                else
                begin
                    o_p_drive[ch] <= running && p_bit && p_window;
                    o_n_drive[ch] <= running && n_bit;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_top_control   <= beam_fire_pkg::TOP_RESET;
            o_pll_enable    <= 1'b0;
            o_firing_active <= 1'b0;
        end
        else
        begin
            o_top_control   <= top_control;
            o_pll_enable    <= top_control[beam_fire_pkg::TOP_PLL_BIT];
            o_firing_active <= (state == beam_fire_pkg::ST_LATENCY) || (state == beam_fire_pkg::ST_FIRING);
        end
    end

endmodule : beam_fire_control

`default_nettype wire

// file: dv/beam_fire_control_asserts.sv
// Port checker for the beam firing control block.
// Assumes it is bound to beam_fire_control and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module beam_fire_control_asserts #(
    parameter int CHANNELS = 8
) (
    input wire logic                i_clock,
    input wire logic                i_rst,
    input wire logic                i_fire_trigger,
    input wire logic                i_reg_write,
    input wire logic [4:0]          i_reg_addr,
    input wire logic [63:0]         i_reg_data,
    input wire logic [13:0]         o_top_control,
    input wire logic                o_pll_enable,
    input wire logic                o_firing_active,
    input wire logic [CHANNELS-1:0] o_p_drive,
    input wire logic [CHANNELS-1:0] o_n_drive
);
    // ------------------------------------------------------------
    // Helpers and assertions
    // ------------------------------------------------------------
    // Named terms keep each property to one idea
    wire quiet  = (o_p_drive == '0) && (o_n_drive == '0);
    wire top_wr = i_reg_write && (i_reg_addr == 5'h1A);

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    reset_clear_a : assert property ($past(i_rst) |-> quiet && !o_firing_active && !o_pll_enable)
        else $error("outputs not cleared after reset");
    top_reserved_a : assert property (o_top_control[13] == 1'b0)
        else $error("reserved top control bit set");
    top_write_a : assert property (top_wr ##1 !top_wr [*2] |=>
        o_top_control == ($past(i_reg_data[13:0], 3) & 14'h1FFF))
        else $error("top control does not follow write");
    latency_quiet_a : assert property ($rose(i_fire_trigger) && !o_firing_active |=>
        quiet throughout (1'b1 ##48 1'b1))
        else $error("drive during fixed latency");
    active_start_a : assert property ($rose(i_fire_trigger) && !o_firing_active |-> ##[1:3] o_firing_active)
        else $error("firing not started by trigger");
    abort_quiet_a : assert property (!i_fire_trigger [*5] |-> quiet)
        else $error("drive while trigger low");
    idle_inactive_a : assert property (!i_fire_trigger [*5] |-> !o_firing_active)
        else $error("active while trigger low");
    drive_window_a : assert property (!quiet |-> o_firing_active || $past(o_firing_active) ||
        $past(o_firing_active, 2) || $past(o_firing_active, 3))
        else $error("drive outside a firing");
endmodule : beam_fire_control_asserts

bind beam_fire_control beam_fire_control_asserts #(.CHANNELS(CHANNELS)) u_asserts (
    .i_clock         (i_clock),
    .i_rst           (i_rst),
    .i_fire_trigger  (i_fire_trigger),
    .i_reg_write     (i_reg_write),
    .i_reg_addr      (i_reg_addr),
    .i_reg_data      (i_reg_data),
    .o_top_control   (o_top_control),
    .o_pll_enable    (o_pll_enable),
    .o_firing_active (o_firing_active),
    .o_p_drive       (o_p_drive),
    .o_n_drive       (o_n_drive)
);

`default_nettype wire

// file: dv/fire_ctrl_model.sv
// System controller model: raises the fire trigger and keeps it for a firing.
// Assumes one go pulse per firing; hold of zero means wait for the end.
`timescale 1ns/1ps
`default_nettype none

module fire_ctrl_model (
    input  wire logic        i_clock,
    input  wire logic        i_go,
    input  wire logic [15:0] i_hold,
    input  wire logic        i_firing_active,
    output var  logic        o_fire_trigger,
    output var  logic        o_done
);
    // Trigger stays high until every channel is done, or for a fixed hold
    initial
    begin
        o_fire_trigger = 1'b0;
        o_done = 1'b0;
        forever
        begin
            @(posedge i_clock);
            o_done <= 1'b0;
            if (i_go)
            begin
                o_fire_trigger <= 1'b1;
                if (i_hold != 16'h0000)
                    repeat (i_hold) @(posedge i_clock);
                else
                begin
                    @(posedge i_clock iff i_firing_active);
                    @(posedge i_clock iff !i_firing_active);
                    repeat (2) @(posedge i_clock); // Let the output pipeline drain
                end
                o_fire_trigger <= 1'b0;
                repeat (4) @(posedge i_clock);
                o_done <= 1'b1;
            end
        end
    end
endmodule : fire_ctrl_model

`default_nettype wire

// file: dv/tb.sv
// Self-checking bench: register writes, code, alternate and continuous firings.
// Assumes the controller model drives the trigger; expectations come from shadows.
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ------------------------------------------------------------
    // Signals, shadows and helpers
    // ------------------------------------------------------------
    localparam int LAG = 51; // Negedges from first high trigger to tick 0
    localparam int LENS [8] = '{4, 8, 16, 24, 32, 40, 48, 64};
    logic        i_clock = 1'b0;
    logic        i_rst = 1'b1;
    logic        wr = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [63:0] data = 64'h0;
    logic        go = 1'b0;
    logic [15:0] hold = 16'h0000;
    logic        trig, done, active, pll;
    logic [13:0] top_seen;
    logic [7:0]  p_seen, n_seen;
    logic [21:0] dly [8];
    logic [63:0] pp [8];
    logic [63:0] np [8];
    logic [13:0] top = 14'h0000;
    logic        inv = 1'b0;
    int          mismatches = 0;
    int          checks = 0;
    int          k = -1;

    always #2.5 i_clock = ~i_clock;

    beam_fire_control #(.CHANNELS(8)) dut (
        .i_clock        (i_clock),
        .i_rst          (i_rst),
        .i_fire_trigger (trig),
        .i_reg_write    (wr),
        .i_reg_addr     (addr),
        .i_reg_data     (data),
        .o_top_control  (top_seen),
        .o_pll_enable   (pll),
        .o_firing_active(active),
        .o_p_drive      (p_seen),
        .o_n_drive      (n_seen)
    );

    fire_ctrl_model ctrl (
        .i_clock        (i_clock),
        .i_go           (go),
        .i_hold         (hold),
        .i_firing_active(active),
        .o_fire_trigger (trig),
        .o_done         (done)
    );

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // Expected drive per channel at negedge t after the trigger went high
    function automatic logic [7:0] exp_vec(int t, bit isp);
        logic [7:0]  v;
        logic [63:0] pat;
        int          w, s, idx, off, pk;
        v = 8'h00;
        w = 8 * ((top[9:3] == 7'h00) ? 128 : int'(top[9:3]));
        for (int ch = 0; ch < 8; ch++)
        begin
            s = t - LAG - 8 * int'(dly[ch][16:3]) - int'(dly[ch][2:0]);
            pk = dly[ch][21] ? int'(dly[ch][19:17]) : 0;
            if (s < 0) continue;
            idx = s / w;
            off = s % w;
            pat = top[12] ? (isp ? beam_fire_pkg::CW_P_PATTERN : beam_fire_pkg::CW_N_PATTERN) : (isp ? pp[ch] : np[ch]);
            if (top[12]) idx = idx % LENS[top[2:0]]; // Circular replay
            if (idx < LENS[top[2:0]] && !(isp && (off < pk || off >= w - pk)))
                v[ch] = pat[idx] ^ (inv && !top[12]);
        end
        return v;
    endfunction : exp_vec

    task automatic write_reg(input logic [4:0] a, input logic [63:0] d);
        @(posedge i_clock);
        wr <= 1'b1;
        addr <= a;
        data <= d;
        @(posedge i_clock);
        wr <= 1'b0;
        if (a < 5'h08) dly[a[2:0]] = d[21:0];
        else if (a < 5'h10) pp[a[2:0]] = d;
        else if (a < 5'h18) np[a[2:0]] = d;
        else if (a == 5'h18 && !top[12]) foreach (pp[i]) pp[i] = d;
        else if (a == 5'h19 && !top[12]) foreach (np[i]) np[i] = d;
        else if (a == 5'h1A)
        begin
            if (!d[11]) inv = 1'b0;
            top = d[13:0] & beam_fire_pkg::TOP_WRITE_MASK;
            repeat (2) @(posedge i_clock);
            #1;
            check(top_seen, top);
            check(pll, top[10]);
        end
    endtask : write_reg

    // Bounded wait for the controller model to finish a firing
    task automatic fire(input logic [15:0] h);
        int n;
        n = 0;
        @(posedge i_clock);
        go <= 1'b1;
        hold <= h;
        @(posedge i_clock);
        go <= 1'b0;
        while (done !== 1'b1 && n < 20000)
        begin
            @(posedge i_clock);
            n++;
        end
        if (n >= 20000)
        begin
            mismatches++;
            finish_test();
        end
        else if (top[11])
            inv = !inv;
    endtask : fire

    // Every cycle of a firing is compared, latency included
    always @(negedge i_clock)
    begin
        if (trig !== 1'b1)
            k = -1;
        else
        begin
            k = k + 1;
            check(p_seen, exp_vec(k, 1'b1));
            check(n_seen, exp_vec(k, 1'b0));
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [63:0] x;
        foreach (dly[i]) dly[i] = beam_fire_pkg::DELAY_RESET;
        foreach (pp[i]) pp[i] = beam_fire_pkg::P_PATTERN_RESET;
        foreach (np[i]) np[i] = beam_fire_pkg::N_PATTERN_RESET;
        void'($urandom(23));
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        #1;
        check({top_seen, p_seen, n_seen, active}, 31'h0);
        write_reg(5'h1A, 64'h3FFF);
        write_reg(5'h1B, 64'hFFFF_FFFF_FFFF_FFFF);
        write_reg(5'h1F, 64'hFFFF_FFFF_FFFF_FFFF);
        // Random code firings over every length code, last one divider zero
        for (int c = 0; c < 9; c++)
        begin
            for (int ch = 0; ch < 8; ch++)
            begin
                write_reg(5'(ch), {42'h0, 1'($urandom), 1'b0, 3'($urandom), 14'($urandom_range(15)), 3'($urandom)});
                write_reg(5'(8 + ch), {$urandom, $urandom});
                write_reg(5'(16 + ch), {$urandom, $urandom});
            end
            if (c % 3 == 1) write_reg(5'h18, {$urandom, $urandom});
            if (c % 3 == 1) write_reg(5'h19, {$urandom, $urandom});
            write_reg(5'h1A, {53'h0, 1'($urandom), (c == 8) ? 7'h00 : 7'($urandom_range(3, 2)), 3'(c % 8)});
            fire(16'h0000);
        end
        // Alternate polarity, then plain again with delays kept
        write_reg(5'h1A, 64'h0811);
        repeat (3) fire(16'h0000);
        write_reg(5'h1A, 64'h0011);
        repeat (2) fire(16'h0000);
        // Continuous wave refuses shared pattern writes
        x = {$urandom, $urandom};
        write_reg(5'h18, x);
        write_reg(5'h1A, 64'h1040);
        write_reg(5'h18, ~x);
        write_reg(5'h00, 64'h19);
        fire(16'h0BB8);
        write_reg(5'h1A, 64'h0040);
        fire(16'h0000);
        finish_test();
    end
endmodule : tb

`default_nettype wire
